// ===== bench/iinw_master.sv
// master station model: takes response bytes off the link, can stall
// assumes one byte stream on ref_clk with valid/ready handshake
`timescale 1ns/1ns
`default_nettype none
module iin_master
    import iin_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link side of the response stream
    input wire logic rsp_out_valid,
    input wire iin_byte_t rsp_out_data,
    input wire logic rsp_out_last,
    output logic rsp_out_ready,
    // control and results
    input wire logic slow,
    output logic [2:0] poll_class,
    output logic [7:0] frames,
    output iin_byte_t tail
);
    iin_byte_t got[$];
    int idx;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_out_ready <= 1'b0;
            poll_class <= 3'h0;
            frames <= 8'h00;
            tail <= 8'h00;
            idx = 0;
        end else begin
            // slow mode drops ready every other cycle so the output slot must hold
            rsp_out_ready <= slow ? ~rsp_out_ready : 1'b1;
            if (rsp_out_valid && rsp_out_ready) begin
                got.push_back(rsp_out_data);
                // first indication byte decides which classes get polled next
                if (idx == 1) begin
                    poll_class <= rsp_out_data[3:1];
                end
                idx = rsp_out_last ? 0 : idx + 1;
                if (rsp_out_last) begin
                    frames <= frames + 8'h01;
                    tail <= rsp_out_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench of the indication word block with a master model
// assumes the design's registered timing as handed over; inputs driven 1 ns after the edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import iin_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0, req_func_ok = 1'b1, req_obj_known = 1'b1, req_params_ok = 1'b1;
    logic req_multi_frame = 1'b0, req_time_write = 1'b0, req_restart_clr = 1'b0;
    logic [15:0] req_dest = 16'h0001;
    logic [2:0] class_pending = 3'h0;
    logic xfer_fail = 1'b0, buf_overflow = 1'b0, cfg_invalid = 1'b0, warm_boot = 1'b0;
    logic time_lost = 1'b0, event_in = 1'b0, event_out, slow = 1'b0;
    logic rsp_in_valid = 1'b0, rsp_in_fc = 1'b0, rsp_in_last = 1'b0, rsp_in_ready;
    iin_byte_t rsp_in_data = 8'h00;
    logic rsp_out_valid, rsp_out_last, rsp_out_ready, cfg_use_defaults;
    iin_byte_t rsp_out_data;
    iin_word_t iin_word_out;
    logic [2:0] poll_class;
    logic [7:0] frames;
    iin_byte_t tail;
    int error_cnt = 0;
    int total_checks = 0;

    always #5 ref_clk = ~ref_clk;

    iin_word dut (.ref_clk, .rst_n, .req_valid, .req_dest, .req_func_ok, .req_obj_known,
        .req_params_ok, .req_multi_frame, .req_time_write, .req_restart_clr, .class_pending,
        .xfer_fail, .buf_overflow, .cfg_invalid, .warm_boot, .time_lost, .event_in,
        .event_out, .rsp_in_valid, .rsp_in_data, .rsp_in_fc, .rsp_in_last, .rsp_in_ready,
        .rsp_out_valid, .rsp_out_data, .rsp_out_last, .rsp_out_ready, .iin_word_out,
        .cfg_use_defaults);

    iin_master partner (.ref_clk, .rst_n, .rsp_out_valid, .rsp_out_data, .rsp_out_last,
        .rsp_out_ready, .slow, .poll_class, .frames, .tail);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task conclude;
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // one master request; fields go back to a clean request afterwards
    task req(input logic [15:0] dest, input logic [3:0] ok_mf, input logic tw, input logic rc);
        req_dest = dest;
        {req_func_ok, req_obj_known, req_params_ok, req_multi_frame} = ok_mf;
        req_time_write = tw;
        req_restart_clr = rc;
        req_valid = 1'b1;
        tick(1);
        req_valid = 1'b0;
        req_time_write = 1'b0;
        req_restart_clr = 1'b0;
        {req_func_ok, req_obj_known, req_params_ok, req_multi_frame} = 4'hE;
    endtask

    task send(input iin_byte_t d, input logic fc, input logic last);
        int n;
        n = 0;
        rsp_in_valid = 1'b1;
        rsp_in_data = d;
        rsp_in_fc = fc;
        rsp_in_last = last;
        while (rsp_in_ready !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if (n == 50) begin
            error_cnt++;
            conclude();
        end
        tick(1);
    endtask

    // fc byte, then a last byte unless len is 3; valid stays up between bytes
    task frame(input int base, input logic [31:0] exp, input int len);
        int n;
        send(exp[31:24], 1'b1, len == 3);
        if (len == 4) begin
            send(exp[7:0], 1'b0, 1'b1);
        end
        rsp_in_valid = 1'b0;
        rsp_in_fc = 1'b0;
        rsp_in_last = 1'b0;
        n = 0;
        while (partner.got.size() < base + len && n < 100) begin
            tick(1);
            n++;
        end
        if (n == 100) begin
            error_cnt++;
            conclude();
        end
        for (int i = 0; i < len; i++) begin
            check("stream byte", {8'h00, partner.got[base + i]}, {8'h00, exp[31 - 8 * i -: 8]});
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        tick(4);
        rst_n = 1'b1;
        tick(1);
        check("word after reset", iin_word_out, 16'h0090);
        event_in = 1'b1;
        tick(1);
        event_in = 1'b0;
        check("event while restart", {15'h0, event_out}, 16'h0000);
        req(16'h0001, 4'hE, 1'b0, 1'b1);
        tick(1);
        check("restart cleared", iin_word_out, 16'h0010);
        event_in = 1'b1;
        tick(1);
        event_in = 1'b0;
        check("event passes", {15'h0, event_out}, 16'h0001);
        req(16'h0001, 4'hE, 1'b1, 1'b0);
        check("time write", iin_word_out, 16'h0000);
        time_lost = 1'b1;
        tick(1);
        time_lost = 1'b0;
        check("time lost", iin_word_out, 16'h0010);
        warm_boot = 1'b1;
        tick(1);
        warm_boot = 1'b0;
        check("warm boot", iin_word_out, 16'h0090);
        req(16'h0001, 4'hE, 1'b1, 1'b1);
        check("both cleared", iin_word_out, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            class_pending = 3'h1 << i;
            tick(1);
            check("class pending", {13'h0, iin_word_out[3:1]}, 16'h1 << i);
        end
        class_pending = 3'h5;
        xfer_fail = 1'b1;
        cfg_invalid = 1'b1;
        tick(2);
        check("trouble and config", iin_word_out, 16'h204A);
        check("defaults used", {15'h0, cfg_use_defaults}, 16'h0001);
        xfer_fail = 1'b0;
        cfg_invalid = 1'b0;
        tick(2);
        check("trouble gone", iin_word_out, 16'h000A);
        check("defaults dropped", {15'h0, cfg_use_defaults}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            req(16'h0001, {k != 0, k != 1, k != 2, k == 3}, 1'b0, 1'b0);
            tick(1);
            check("request error", {12'h0, iin_word_out[11:8]}, 16'h1 << k);
        end
        req(16'h0001, 4'hE, 1'b0, 1'b0);
        tick(1);
        check("errors recomputed", iin_word_out, 16'h000A);
        req(16'hFFFF, 4'h6, 1'b0, 1'b0);
        check("broadcast seen", {15'h0, iin_word_out[0]}, 16'h0001);
        buf_overflow = 1'b1;
        tick(1);
        buf_overflow = 1'b0;
        check("overflow word", iin_word_out, 16'h090B);
        slow = 1'b1;
        frame(0, 32'h810B_09C3, 4);
        check("master polls", {13'h0, poll_class}, 16'h0005);
        tick(3);
        check("cleared after response", iin_word_out, 16'h010A);
        slow = 1'b0;
        frame(4, 32'h820A_0155, 4);
        check("frames seen", {8'h00, frames}, 16'h0002);
        frame(8, 32'h830A_0100, 3);
        check("frames seen", {8'h00, frames}, 16'h0003);
        check("end mark on word", {8'h00, tail}, 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire

// ===== rtl/iin_consts.svh
// bit positions, reset values and fixed codes of the indication word
// assumes first byte in word bits 7:0, second byte in bits 15:8
`ifndef IIN_CONSTS_SVH
`define IIN_CONSTS_SVH

// ----------------------------------------
// first byte
// ----------------------------------------
`define IIN_B_BCAST 0
`define IIN_B_CLASS1 1
`define IIN_B_CLASS3 3
`define IIN_B_TSYNC 4
`define IIN_B_LOCAL 5
`define IIN_B_TROUBLE 6
`define IIN_B_RESTART 7

// ----------------------------------------
// second byte
// ----------------------------------------
`define IIN_B_BADFUNC 8
`define IIN_B_UNKOBJ 9
`define IIN_B_BADPARM 10
`define IIN_B_OVERFLOW 11
`define IIN_B_BUSY 12
`define IIN_B_BADCFG 13
`define IIN_B_RSVD_LO 14
`define IIN_B_RSVD_HI 15

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define IIN_ALL_STATIONS 16'hFFFF
`define IIN_RST_RESTART 1'h1
`define IIN_RST_TSYNC 1'h1
`define IIN_RST_WORD 16'h0090

`endif

// ===== rtl/iin_err_eval.sv
// per-request error flags, recomputed on each new request
// assumes request fields are valid in the req_valid cycle
`timescale 1ns/1ns
`default_nettype none
module iin_err_eval
    import iin_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // request side
    iin_req_if.eval req
);

    iin_req_err_t err_reg;
    iin_req_err_t err_next;

    // a new request replaces the previous result entirely
    always_comb begin
        err_next = err_reg;
        if (req.req_valid) begin
            err_next.bad_func = ~req.func_ok;
            err_next.unk_obj = ~req.obj_known;
            err_next.bad_parm = ~req.params_ok;
            err_next.multi_frame = req.multi_frame;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= '0;
        end else begin
            err_reg <= err_next;
        end
    end

    assign req.err = err_reg;

endmodule
`default_nettype wire

// ===== rtl/iin_inserter.sv
// puts the two indication bytes behind the function code of a response stream
// assumes the builder marks the function code byte and the last byte
`timescale 1ns/1ns
`default_nettype none
module iin_inserter
    import iin_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // word to insert
    input wire iin_word_t word,
    // stream from the response builder
    input wire logic in_valid,
    input wire iin_byte_t in_data,
    input wire logic in_fc,
    input wire logic in_last,
    output logic in_ready,
    // stream to the link
    output logic out_valid,
    output iin_byte_t out_data,
    output logic out_last,
    input wire logic out_ready,
    // last byte of a response has left
    output logic sent
);

    iin_ins_state_t state_reg, state_next;
    iin_word_t snap_reg, snap_next;
    logic ov_reg, ov_next;
    iin_byte_t od_reg, od_next;
    logic ol_reg, ol_next;
    logic rdy_reg, rdy_next;
    logic sent_reg, sent_next;
    logic fcl_reg, fcl_next;
    logic slot_free;
    logic take;

    // ready is registered, so at most one byte in two cycles is taken
    always_comb begin
        state_next = state_reg;
        snap_next = snap_reg;
        ov_next = ov_reg;
        od_next = od_reg;
        ol_next = ol_reg;
        fcl_next = fcl_reg;
        slot_free = !ov_reg || out_ready;
        take = in_valid && rdy_reg;
        sent_next = ov_reg && out_ready && ol_reg;
        if (ov_reg && out_ready) begin
            ov_next = 1'b0;
        end
        unique case (state_reg)
            IIN_PASS: begin
                if (take) begin
                    ov_next = 1'b1;
                    od_next = in_data;
                    ol_next = in_last;
                    if (in_fc) begin
                        // the word always follows, so an end mark moves to its second byte
                        ol_next = 1'b0;
                        fcl_next = in_last;
                        snap_next = word;
                        state_next = IIN_FIRST;
                    end
                end
            end
            IIN_FIRST: begin
                if (slot_free) begin
                    ov_next = 1'b1;
                    od_next = snap_reg[7:0];
                    ol_next = 1'b0;
                    state_next = IIN_SECOND;
                end
            end
            IIN_SECOND: begin
                if (slot_free) begin
                    ov_next = 1'b1;
                    od_next = snap_reg[15:8];
                    ol_next = fcl_reg;
                    state_next = IIN_PASS;
                end
            end
        endcase
        rdy_next = (state_next == IIN_PASS) && !ov_next;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= IIN_PASS;
            snap_reg <= '0;
            ov_reg <= 1'b0;
            od_reg <= '0;
            ol_reg <= 1'b0;
            rdy_reg <= 1'b0;
            sent_reg <= 1'b0;
            fcl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            snap_reg <= snap_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
            ol_reg <= ol_next;
            rdy_reg <= rdy_next;
            sent_reg <= sent_next;
            fcl_reg <= fcl_next;
        end
    end

    assign in_ready = rdy_reg;
    assign out_valid = ov_reg;
    assign out_data = od_reg;
    assign out_last = ol_reg;
    assign sent = sent_reg;

endmodule
`default_nettype wire

// ===== rtl/iin_pkg.sv
// types shared by the indication word block
// assumes nothing beyond the constants header
package iin_pkg;

    typedef logic [15:0] iin_word_t;

    typedef logic [7:0] iin_byte_t;

    typedef enum logic [1:0] {
        IIN_PASS,
        IIN_FIRST,
        IIN_SECOND
    } iin_ins_state_t;

    // per-request error results
    typedef struct packed {
        logic multi_frame;
        logic bad_parm;
        logic unk_obj;
        logic bad_func;
    } iin_req_err_t;

endpackage

// ===== rtl/iin_req_if.sv
// request decode results passed from the top to the error evaluator
// assumes all signals on ref_clk
`timescale 1ns/1ns
`default_nettype none
interface iin_req_if;
    import iin_pkg::*;

    logic req_valid;
    logic func_ok;
    logic obj_known;
    logic params_ok;
    logic multi_frame;
    iin_req_err_t err;

    modport top (output req_valid, output func_ok, output obj_known, output params_ok,
                 output multi_frame, input err);
    modport eval (input req_valid, input func_ok, input obj_known, input params_ok,
                  input multi_frame, output err);
endinterface
`default_nettype wire

// ===== rtl/iin_word.sv
// internal indication word of a slave station: flags, events gate, response insertion
// assumes every input comes from logic on ref_clk; pulses last one cycle
`timescale 1ns/1ns
`default_nettype none
`include "iin_consts.svh"
module iin_word
    import iin_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // decoded request
    input wire logic req_valid,
    input wire logic [15:0] req_dest,
    input wire logic req_func_ok,
    input wire logic req_obj_known,
    input wire logic req_params_ok,
    input wire logic req_multi_frame,
    input wire logic req_time_write,
    input wire logic req_restart_clr,
    // device status
    input wire logic [2:0] class_pending,
    input wire logic xfer_fail,
    input wire logic buf_overflow,
    input wire logic cfg_invalid,
    input wire logic warm_boot,
    input wire logic time_lost,
    // event gate
    input wire logic event_in,
    output logic event_out,
    // response stream in
    input wire logic rsp_in_valid,
    input wire iin_byte_t rsp_in_data,
    input wire logic rsp_in_fc,
    input wire logic rsp_in_last,
    output logic rsp_in_ready,
    // response stream out
    output logic rsp_out_valid,
    output iin_byte_t rsp_out_data,
    output logic rsp_out_last,
    input wire logic rsp_out_ready,
    // status
    output iin_word_t iin_word_out,
    output logic cfg_use_defaults
);

    // ----------------------------------------
    // flag state
    // ----------------------------------------
    logic bcast_reg, bcast_next;
    logic tsync_reg, tsync_next;
    logic restart_reg, restart_next;
    logic ovf_reg, ovf_next;
    iin_word_t word_reg, word_next;
    logic ev_reg, ev_next;
    logic dflt_reg, dflt_next;
    logic rsp_sent;
    logic bcast_set;

    iin_req_if req_bus();

    assign req_bus.req_valid = req_valid;
    assign req_bus.func_ok = req_func_ok;
    assign req_bus.obj_known = req_obj_known;
    assign req_bus.params_ok = req_params_ok;
    assign req_bus.multi_frame = req_multi_frame;

    iin_err_eval u_err (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .req(req_bus.eval)
    );

    // ----------------------------------------
    // word assembly
    // ----------------------------------------
    function automatic iin_word_t build_word(
        input logic bcast,
        input logic [2:0] cls,
        input logic tsync,
        input logic trouble,
        input logic restart,
        input iin_req_err_t err,
        input logic ovf,
        input logic badcfg
    );
        iin_word_t w;
        w = '0;
        w[`IIN_B_BCAST] = bcast;
        w[`IIN_B_CLASS3:`IIN_B_CLASS1] = cls;
        w[`IIN_B_TSYNC] = tsync;
        w[`IIN_B_LOCAL] = 1'b0;
        w[`IIN_B_TROUBLE] = trouble;
        w[`IIN_B_RESTART] = restart;
        w[`IIN_B_BADFUNC] = err.bad_func;
        w[`IIN_B_UNKOBJ] = err.unk_obj;
        w[`IIN_B_BADPARM] = err.bad_parm;
        w[`IIN_B_OVERFLOW] = ovf | err.multi_frame;
        w[`IIN_B_BUSY] = 1'b0;
        w[`IIN_B_BADCFG] = badcfg;
        w[`IIN_B_RSVD_HI:`IIN_B_RSVD_LO] = 2'h0;
        return w;
    endfunction

    // set always wins over clear on the same edge
    always_comb begin
        bcast_set = req_valid && (req_dest == `IIN_ALL_STATIONS);
        bcast_next = bcast_reg;
        if (rsp_sent) begin
            bcast_next = 1'b0;
        end
        if (bcast_set) begin
            bcast_next = 1'b1;
        end
        tsync_next = tsync_reg;
        if (req_valid && req_time_write) begin
            tsync_next = 1'b0;
        end
        if (time_lost || warm_boot) begin
            tsync_next = 1'b1;
        end
        restart_next = restart_reg;
        if (req_valid && req_restart_clr) begin
            restart_next = 1'b0;
        end
        if (warm_boot) begin
            restart_next = 1'b1;
        end
        // overflow holds until the last byte of a response has left, even one whose word was taken before the overflow
        ovf_next = ovf_reg;
        if (rsp_sent) begin
            ovf_next = 1'b0;
        end
        if (buf_overflow) begin
            ovf_next = 1'b1;
        end
        ev_next = event_in && !restart_reg;
        dflt_next = cfg_invalid;
        word_next = build_word(bcast_next, class_pending, tsync_next, xfer_fail,
                               restart_next, req_bus.err, ovf_next, cfg_invalid);
    end

    // cold boot is the reset itself, hence restart and time sync start set
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcast_reg <= 1'b0;
            tsync_reg <= `IIN_RST_TSYNC;
            restart_reg <= `IIN_RST_RESTART;
            ovf_reg <= 1'b0;
            word_reg <= `IIN_RST_WORD;
            ev_reg <= 1'b0;
            dflt_reg <= 1'b0;
        end else begin
            bcast_reg <= bcast_next;
            tsync_reg <= tsync_next;
            restart_reg <= restart_next;
            ovf_reg <= ovf_next;
            word_reg <= word_next;
            ev_reg <= ev_next;
            dflt_reg <= dflt_next;
        end
    end

    // ----------------------------------------
    // response insertion
    // ----------------------------------------
    iin_inserter u_ins (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .word(word_reg),
        .in_valid(rsp_in_valid),
        .in_data(rsp_in_data),
        .in_fc(rsp_in_fc),
        .in_last(rsp_in_last),
        .in_ready(rsp_in_ready),
        .out_valid(rsp_out_valid),
        .out_data(rsp_out_data),
        .out_last(rsp_out_last),
        .out_ready(rsp_out_ready),
        .sent(rsp_sent)
    );

    assign iin_word_out = word_reg;
    assign event_out = ev_reg;
    assign cfg_use_defaults = dflt_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_bcast_set;
        @(posedge ref_clk) disable iff (!rst_n)
        (req_valid && req_dest == `IIN_ALL_STATIONS) |=> iin_word_out[`IIN_B_BCAST];
    endproperty
    a_bcast_set: assert property (p_bcast_set) else $error("broadcast bit not set");

    property p_bcast_clr;
        @(posedge ref_clk) disable iff (!rst_n)
        (rsp_sent && !(req_valid && req_dest == `IIN_ALL_STATIONS)) |=> !iin_word_out[`IIN_B_BCAST];
    endproperty
    a_bcast_clr: assert property (p_bcast_clr) else $error("broadcast bit kept after response");

    property p_class;
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 iin_word_out[`IIN_B_CLASS3:`IIN_B_CLASS1] == $past(class_pending);
    endproperty
    a_class: assert property (p_class) else $error("class pending bits wrong");

    property p_tsync_clr;
        @(posedge ref_clk) disable iff (!rst_n)
        (req_valid && req_time_write && !time_lost && !warm_boot) |=> !iin_word_out[`IIN_B_TSYNC];
    endproperty
    a_tsync_clr: assert property (p_tsync_clr) else $error("time sync bit not cleared");

    property p_zero_bits;
        @(posedge ref_clk) disable iff (!rst_n)
        !iin_word_out[`IIN_B_LOCAL] && !iin_word_out[`IIN_B_BUSY]
            && iin_word_out[`IIN_B_RSVD_HI:`IIN_B_RSVD_LO] == 2'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed zero bit set");

    property p_restart_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (iin_word_out[`IIN_B_RESTART] && !(req_valid && req_restart_clr)) |=> iin_word_out[`IIN_B_RESTART];
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart cleared without master write");

    property p_event_gate;
        @(posedge ref_clk) disable iff (!rst_n)
        (event_in && iin_word_out[`IIN_B_RESTART]) |=> !event_out;
    endproperty
    a_event_gate: assert property (p_event_gate) else $error("event passed during restart");

    property p_req_err;
        @(posedge ref_clk) disable iff (!rst_n)
        req_valid |=> ##1 (iin_word_out[`IIN_B_BADFUNC] == !$past(req_func_ok, 2))
            && (iin_word_out[`IIN_B_UNKOBJ] == !$past(req_obj_known, 2))
            && (iin_word_out[`IIN_B_BADPARM] == !$past(req_params_ok, 2));
    endproperty
    a_req_err: assert property (p_req_err) else $error("request error bits wrong");

    property p_trouble_cfg;
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 (iin_word_out[`IIN_B_TROUBLE] == $past(xfer_fail))
            && (iin_word_out[`IIN_B_BADCFG] == $past(cfg_invalid));
    endproperty
    a_trouble_cfg: assert property (p_trouble_cfg) else $error("trouble or config bit wrong");

    property p_ovf;
        @(posedge ref_clk) disable iff (!rst_n)
        buf_overflow |=> iin_word_out[`IIN_B_OVERFLOW];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow bit not set");

    property p_restart_set;
        @(posedge ref_clk) disable iff (!rst_n)
        warm_boot |=> iin_word_out[`IIN_B_RESTART];
    endproperty
    a_restart_set: assert property (p_restart_set) else $error("restart bit not set on boot");

    property p_tsync_set;
        @(posedge ref_clk) disable iff (!rst_n)
        (time_lost || warm_boot) |=> iin_word_out[`IIN_B_TSYNC];
    endproperty
    a_tsync_set: assert property (p_tsync_set) else $error("time sync bit not set");

    property p_defaults;
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 cfg_use_defaults == $past(cfg_invalid);
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults flag wrong");

    property p_insert;
        @(posedge ref_clk) disable iff (!rst_n)
        (rsp_in_valid && rsp_in_ready && rsp_in_fc) |=> rsp_out_valid && !rsp_out_last && !rsp_in_ready;
    endproperty
    a_insert: assert property (p_insert) else $error("function code byte ended the response");

    property p_event_pass;
        @(posedge ref_clk) disable iff (!rst_n)
        (event_in && !iin_word_out[`IIN_B_RESTART]) |=> event_out;
    endproperty
    a_event_pass: assert property (p_event_pass) else $error("event lost after restart cleared");

endmodule
`default_nettype wire
